//--- ata_sector_write_commands.sv
`timescale 1ns/1ns
`default_nettype none
module ata_sector_write_commands
  import ata_write_pkg::*;
#(
  parameter int SECTORS_PER_TRACK = 63,
  parameter int HEADS             = 16
) (
  // clock and reset
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_sys_rst,
  // axi4-lite write address and data
  input  wire logic                         i_s_axi_awvalid,
  output var  logic                         o_s_axi_awready,
  input  wire logic [ata_write_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic                         i_s_axi_wvalid,
  output var  logic                         o_s_axi_wready,
  input  wire logic [ata_write_pkg::DATA_W-1:0] i_s_axi_wdata,
  input  wire logic [3:0]                   i_s_axi_wstrb,
  // axi4-lite write response
  output var  logic                         o_s_axi_bvalid,
  input  wire logic                         i_s_axi_bready,
  output var  logic [1:0]                   o_s_axi_bresp,
  // axi4-lite read
  input  wire logic                         i_s_axi_arvalid,
  output var  logic                         o_s_axi_arready,
  input  wire logic [ata_write_pkg::ADDR_W-1:0] i_s_axi_araddr,
  output var  logic                         o_s_axi_rvalid,
  input  wire logic                         i_s_axi_rready,
  output var  logic [ata_write_pkg::DATA_W-1:0] o_s_axi_rdata,
  output var  logic [1:0]                   o_s_axi_rresp,
  // host interrupt request
  output var  logic                         o_host_intrq,
  // flash programming engine
  output var  logic                         o_prog_start,
  output var  ata_write_pkg::prog_cmd_type  o_prog_cmd,
  input  wire logic                         i_prog_done,
  input  wire logic                         i_prog_fail,
  input  wire logic [7:0]                   i_buf_rd_addr,
  output var  logic [15:0]                  o_buf_rd_data
);

  generate
    if (SECTORS_PER_TRACK < 1 || SECTORS_PER_TRACK > 255 || HEADS < 1 || HEADS > 16) begin : g_chk
      $error("geometry parameters out of range");
    end
  endgenerate

  localparam logic [7:0] SPT_LAST  = 8'(SECTORS_PER_TRACK);
  localparam logic [3:0] HEAD_LAST = 4'(HEADS - 1);

  typedef enum {ST_IDLE, ST_ACCEPT, ST_FILL, ST_PROG, ST_WAIT} state_type;

  state_type    state_reg;
  logic         awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]   bresp_reg, rresp_reg;
  logic [31:0]  rdata_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]  wdata_reg;
  logic         wstrb0_reg;
  logic [7:0]   feature_reg, length_reg, low_reg, mid_reg, high_reg, unit_reg;
  logic [7:0]   errcode_reg;
  logic         err_reg, intrq_reg, start_reg;
  logic [8:0]   block_cfg_reg;
  logic [8:0]   count_reg;
  logic [7:0]   word_idx_reg;
  logic         skip_erase_reg, verify_reg;
  prog_cmd_type prog_cmd_reg;
  logic [15:0]  buf_rd_reg;
  logic [15:0]  sector_mem [0:SECTOR_WORDS-1];

  // next consecutive sector address, lba or chs
  function automatic logic [27:0] advance(input logic [27:0] a, input logic lba);
    logic [27:0] r;
    r = a;
    if (lba) begin
      r = a + 28'h0000001;
    end else if (a[7:0] < SPT_LAST) begin
      r[7:0] = a[7:0] + 8'h01;
    end else begin
      r[7:0] = 8'h01;
      if (a[27:24] < HEAD_LAST) begin
        r[27:24] = a[27:24] + 4'h1;
      end else begin
        r[27:24] = 4'h0;
        r[23:8]  = a[23:8] + 16'h0001;
      end
    end
    return r;
  endfunction

  // bus decode
  wire         aw_hs     = i_s_axi_awvalid & awready_reg;
  wire         w_hs      = i_s_axi_wvalid & wready_reg;
  wire         b_hs      = bvalid_reg & i_s_axi_bready;
  wire         ar_hs     = i_s_axi_arvalid & arready_reg;
  wire         r_hs      = rvalid_reg & i_s_axi_rready;
  wire         do_write  = ~awready_reg & ~wready_reg & ~bvalid_reg;
  wire         wr_en     = do_write & wstrb0_reg;
  wire         idle      = (state_reg == ST_IDLE);
  wire         tf_write  = wr_en & idle;
  wire         wr_mapped = (awaddr_reg <= OFF_BLOCK_CFG) & (awaddr_reg[1:0] == 2'h0);
  wire         rd_mapped = (i_s_axi_araddr <= OFF_BLOCK_CFG) & (i_s_axi_araddr[1:0] == 2'h0);
  wire [7:0]   opcode    = wdata_reg[7:0];
  wire         cmd_write = tf_write & (awaddr_reg == OFF_CMD_STAT);
  wire         data_write = wr_en & (awaddr_reg == OFF_DATA) & (state_reg == ST_FILL);
  wire         stat_read = ar_hs & (i_s_axi_araddr == OFF_CMD_STAT);
  wire         lba_mode  = unit_reg[UNIT_LBA_BIT];
  wire [27:0]  cur_addr  = {unit_reg[3:0], high_reg, mid_reg, low_reg};
  wire [27:0]  nxt_addr  = advance(cur_addr, lba_mode);

  wire         op_plain  = (opcode == OP_WRITE_A) | (opcode == OP_WRITE_B);
  wire         blk_ok    = block_cfg_reg[BLK_ENABLE_BIT] & (block_cfg_reg[7:0] != 8'h00)
                           & (block_cfg_reg[7:0] == SUPPORTED_BLK);
  wire         op_block  = (opcode == OP_BLOCK_NOERASE);
  wire         op_known  = op_plain | (opcode == OP_WRITE_NOERASE)
                           | (opcode == OP_WRITE_VERIFY) | (op_block & blk_ok);
  wire         cmd_start = cmd_write & op_known;
  wire         cmd_abort = cmd_write & ~op_known;
  wire         last_word = data_write & (word_idx_reg == 8'hFF);
  wire         sect_done = (state_reg == ST_WAIT) & i_prog_done;
  wire         sect_ok   = sect_done & ~i_prog_fail;
  wire         more_left = (count_reg != 9'h001);

  // status byte; busy covers accept, programming and the engine wait after each sector
  wire         bsy       = (state_reg == ST_ACCEPT) | (state_reg == ST_PROG)
                           | (state_reg == ST_WAIT);
  wire         drq       = (state_reg == ST_FILL);
  wire         rdy       = ~bsy;
  // each flag widened before its shift so no bit falls off the top
  wire [7:0]   status    = (8'(bsy) << STAT_BSY_BIT) | (8'(rdy) << STAT_RDY_BIT)
                           | (8'(drq) << STAT_DRQ_BIT) | (8'(err_reg) << STAT_ERR_BIT);

  wire [7:0]   rd_byte   = (i_s_axi_araddr == OFF_FEATURE)   ? feature_reg :
                           (i_s_axi_araddr == OFF_LENGTH)    ? length_reg  :
                           (i_s_axi_araddr == OFF_ADDR_LOW)  ? low_reg     :
                           (i_s_axi_araddr == OFF_ADDR_MID)  ? mid_reg     :
                           (i_s_axi_araddr == OFF_ADDR_HIGH) ? high_reg    :
                           (i_s_axi_araddr == OFF_UNIT)      ? unit_reg    :
                           (i_s_axi_araddr == OFF_CMD_STAT)  ? status      :
                           (i_s_axi_araddr == OFF_ERROR)     ? errcode_reg : 8'h00;
  wire [31:0]  rd_word   = (i_s_axi_araddr == OFF_BLOCK_CFG) ? {23'h000000, block_cfg_reg}
                           : (rd_mapped ? {24'h000000, rd_byte} : 32'h00000000);

  // interrupt events; a set in the clearing cycle wins
  wire         irq_set   = cmd_abort | sect_done;
  wire         intrq_next = irq_set | (intrq_reg & ~stat_read);

  // axi write channels, taken in either order
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h00000000;
      wstrb0_reg  <= 1'b0;
    end else begin
      if (aw_hs) begin
        awready_reg <= 1'b0;
        awaddr_reg  <= i_s_axi_awaddr;
      end
      if (w_hs) begin
        wready_reg <= 1'b0;
        wdata_reg  <= i_s_axi_wdata;
        wstrb0_reg <= i_s_axi_wstrb[0];
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (b_hs) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // axi read channel, answered one cycle after the address
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_word;
      rresp_reg   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (r_hs) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // task file; host writes only land while idle, so the engine owns it during a command
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      feature_reg   <= 8'h00;
      length_reg    <= RST_LENGTH;
      low_reg       <= RST_ADDR_LOW;
      mid_reg       <= 8'h00;
      high_reg      <= 8'h00;
      unit_reg      <= RST_UNIT;
      block_cfg_reg <= RST_BLOCK;
    end else if (sect_ok & more_left) begin
      {unit_reg[3:0], high_reg, mid_reg, low_reg} <= nxt_addr;
      length_reg <= length_reg - 8'h01;
    end else if (sect_ok) begin
      length_reg <= length_reg - 8'h01;
    end else if (tf_write) begin
      unique case (awaddr_reg)
        OFF_FEATURE:   feature_reg   <= wdata_reg[7:0];
        OFF_LENGTH:    length_reg    <= wdata_reg[7:0];
        OFF_ADDR_LOW:  low_reg       <= wdata_reg[7:0];
        OFF_ADDR_MID:  mid_reg       <= wdata_reg[7:0];
        OFF_ADDR_HIGH: high_reg      <= wdata_reg[7:0];
        OFF_UNIT:      unit_reg      <= wdata_reg[7:0];
        OFF_BLOCK_CFG: block_cfg_reg <= wdata_reg[8:0];
        default:       ;
      endcase
    end
  end

  // sector buffer, one sector deep; engine reads it while busy
  always_ff @(posedge i_clk_sys) begin
    if (data_write) begin
      sector_mem[word_idx_reg] <= wdata_reg[15:0];
    end
    buf_rd_reg <= sector_mem[i_buf_rd_addr];
  end

  // command sequencer
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state_reg      <= ST_IDLE;
      err_reg        <= 1'b0;
      errcode_reg    <= 8'h00;
      intrq_reg      <= 1'b0;
      start_reg      <= 1'b0;
      count_reg      <= 9'h000;
      word_idx_reg   <= 8'h00;
      skip_erase_reg <= 1'b0;
      verify_reg     <= 1'b0;
      prog_cmd_reg   <= '0;
    end else begin
      intrq_reg <= intrq_next;
      start_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (cmd_abort) begin
            err_reg     <= 1'b1;
            errcode_reg <= 8'(1 << ERR_ABORT_BIT);
          end else if (cmd_start) begin
            err_reg        <= 1'b0;
            errcode_reg    <= 8'h00;
            count_reg      <= (length_reg == 8'h00) ? MAX_SECTORS : {1'b0, length_reg};
            // engine falls back if not erased
            skip_erase_reg <= op_block | (opcode == OP_WRITE_NOERASE);
            verify_reg     <= (opcode == OP_WRITE_VERIFY);
            word_idx_reg   <= 8'h00;
            state_reg      <= ST_ACCEPT;
          end
        end
        ST_ACCEPT: begin
          state_reg <= ST_FILL;
        end
        ST_FILL: begin
          if (data_write) begin
            word_idx_reg <= word_idx_reg + 8'h01;
          end
          if (last_word) begin
            state_reg <= ST_PROG;
          end
        end
        ST_PROG: begin
          prog_cmd_reg <= '{addr: cur_addr, lba_mode: lba_mode,
                            skip_erase: skip_erase_reg, verify: verify_reg};
          start_reg    <= 1'b1;
          state_reg    <= ST_WAIT;
        end
        ST_WAIT: begin
          if (sect_done & i_prog_fail) begin
            err_reg     <= 1'b1;
            errcode_reg <= 8'(1 << ERR_WRITE_BIT);
            state_reg   <= ST_IDLE;
          end else if (sect_ok & more_left) begin
            count_reg    <= count_reg - 9'h001;
            word_idx_reg <= 8'h00;
            state_reg    <= ST_FILL;
          end else if (sect_ok) begin
            count_reg <= 9'h000;
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign o_s_axi_awready = awready_reg;
  assign o_s_axi_wready  = wready_reg;
  assign o_s_axi_bvalid  = bvalid_reg;
  assign o_s_axi_bresp   = bresp_reg;
  assign o_s_axi_arready = arready_reg;
  assign o_s_axi_rvalid  = rvalid_reg;
  assign o_s_axi_rdata   = rdata_reg;
  assign o_s_axi_rresp   = rresp_reg;
  assign o_host_intrq    = intrq_reg;
  assign o_prog_start    = start_reg;
  assign o_prog_cmd      = prog_cmd_reg;
  assign o_buf_rd_data   = buf_rd_reg;

endmodule // ata_sector_write_commands
`default_nettype wire

//--- ata_write_pkg.sv
`default_nettype none
package ata_write_pkg;

  // register bus geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_DATA      = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_FEATURE   = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_LENGTH    = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_ADDR_LOW  = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_ADDR_MID  = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_ADDR_HIGH = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_UNIT      = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_CMD_STAT  = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_ERROR     = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_BLOCK_CFG = 6'h24;

  // command opcodes
  localparam logic [7:0] OP_WRITE_A       = 8'h30;
  localparam logic [7:0] OP_WRITE_B       = 8'h31;
  localparam logic [7:0] OP_WRITE_NOERASE = 8'h38;
  localparam logic [7:0] OP_WRITE_VERIFY  = 8'h3C;
  localparam logic [7:0] OP_BLOCK_NOERASE = 8'hCD;

  // status, error and config field positions
  localparam int STAT_BSY_BIT   = 7;
  localparam int STAT_RDY_BIT   = 6;
  localparam int STAT_DRQ_BIT   = 3;
  localparam int STAT_ERR_BIT   = 0;
  localparam int ERR_ABORT_BIT  = 2;
  localparam int ERR_WRITE_BIT  = 6;
  localparam int UNIT_LBA_BIT   = 6;
  localparam int BLK_ENABLE_BIT = 8;

  // reset values
  localparam logic [7:0] RST_LENGTH   = 8'h01;
  localparam logic [7:0] RST_ADDR_LOW = 8'h01;
  localparam logic [7:0] RST_UNIT     = 8'hA0;
  localparam logic [8:0] RST_BLOCK    = 9'h000;

  // transfer geometry
  localparam int          SECTOR_WORDS   = 256;
  localparam logic [8:0]  MAX_SECTORS    = 9'h100;
  localparam logic [7:0]  SUPPORTED_BLK  = 8'h01;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // request to the flash programming engine
  typedef struct packed {
    logic [27:0] addr;
    logic        lba_mode;
    logic        skip_erase;
    logic        verify;
  } prog_cmd_type;

endpackage
`default_nettype wire

//--- ata_sector_write_commands_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ata_sector_write_commands_chk #(
  parameter int SECTORS_PER_TRACK = 63,
  parameter int HEADS             = 16
) (
  // clock and reset
  input wire logic                              i_clk_sys,
  input wire logic                              i_sys_rst,
  // register bus
  input wire logic                              i_s_axi_awvalid,
  input wire logic                              o_s_axi_awready,
  input wire logic                              i_s_axi_wvalid,
  input wire logic                              o_s_axi_wready,
  input wire logic                              o_s_axi_bvalid,
  input wire logic                              i_s_axi_bready,
  input wire logic [1:0]                        o_s_axi_bresp,
  input wire logic                              i_s_axi_arvalid,
  input wire logic                              o_s_axi_arready,
  input wire logic [ata_write_pkg::ADDR_W-1:0]  i_s_axi_araddr,
  input wire logic                              o_s_axi_rvalid,
  input wire logic                              i_s_axi_rready,
  input wire logic [ata_write_pkg::DATA_W-1:0]  o_s_axi_rdata,
  input wire logic [1:0]                        o_s_axi_rresp,
  // host and engine side
  input wire logic                              o_host_intrq,
  input wire logic                              o_prog_start,
  input wire ata_write_pkg::prog_cmd_type       o_prog_cmd,
  input wire logic                              i_prog_done,
  input wire logic                              i_prog_fail
);
  import ata_write_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  a_write_answer:
  assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
    |-> ##[1:2] o_s_axi_bvalid) else $error("write response missing");
  a_resp_held:
  assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped");
  a_ready_gap:
  assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer:
  assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read data late");
  a_rdata_held:
  assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped");
  a_bad_read:
  assert property (i_s_axi_arvalid && o_s_axi_arready && (i_s_axi_araddr > OFF_BLOCK_CFG
    || i_s_axi_araddr[1:0] != 2'h0) |=> o_s_axi_rresp == RESP_SLVERR && o_s_axi_rdata == '0)
    else $error("unmapped read not refused");
  a_cmd_steady:
  assert property (o_prog_start |=> $stable(o_prog_cmd) [*8])
    else $error("sector request changed while in use");
  a_done_irq:
  assert property (i_prog_done && !i_prog_fail |-> ##[1:2] o_host_intrq)
    else $error("no interrupt after sector done");
  a_done_quiet:
  assert property (i_prog_done |=> !o_prog_start [*8])
    else $error("sector started without host data");
endmodule // ata_sector_write_commands_chk
bind ata_sector_write_commands ata_sector_write_commands_chk #(
  .SECTORS_PER_TRACK(SECTORS_PER_TRACK), .HEADS(HEADS)) chk_i (.*);
`default_nettype wire

//--- flash_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
module flash_engine_model (
  // clock and reset
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_sys_rst,
  // request from the block
  input  wire logic                          i_start,
  input  wire ata_write_pkg::prog_cmd_type   i_cmd,
  // scenario controls
  input  wire logic                          i_fail_next,
  input  wire logic [3:0]                    i_delay,
  // answer to the block
  output var  logic                          o_done,
  output var  logic                          o_fail,
  output var  logic [7:0]                    o_rd_addr,
  output var  ata_write_pkg::prog_cmd_type   o_last_cmd
);
  import ata_write_pkg::*;
  logic [3:0] cnt_reg;
  logic       busy_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      busy_reg <= 1'h0;
      cnt_reg <= 4'h0;
      o_done <= 1'h0;
      o_fail <= 1'h0;
      o_rd_addr <= 8'h00;
      o_last_cmd <= '0;
    end else begin
      o_done <= busy_reg && cnt_reg == 4'h0;
      // fail toggles outside done so a stale value is never trusted
      o_fail <= (busy_reg && cnt_reg == 4'h0) ? i_fail_next : ~o_fail;
      o_rd_addr <= busy_reg ? o_rd_addr + 8'h01 : 8'h00;
      cnt_reg <= i_start ? i_delay : cnt_reg - 4'h1;
      if (i_start) begin
        busy_reg <= 1'h1;
        o_last_cmd <= i_cmd;
      end else if (cnt_reg == 4'h0) begin
        busy_reg <= 1'h0;
      end
    end
  end
endmodule // flash_engine_model
`default_nettype wire

//--- test_ata_sector_write_commands.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module test_ata_sector_write_commands;
  import ata_write_pkg::*;
  logic                i_clk_sys = 1'h0;
  logic                i_sys_rst = 1'h1;
  logic                i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
  logic                i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0;
  logic [ADDR_W-1:0]   i_s_axi_awaddr = '0, i_s_axi_araddr = '0;
  logic [DATA_W-1:0]   i_s_axi_wdata = '0;
  logic [3:0]          i_s_axi_wstrb = 4'hF;
  logic                o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic                o_s_axi_rvalid, o_host_intrq, o_prog_start, i_prog_done, i_prog_fail;
  logic [1:0]          o_s_axi_bresp, o_s_axi_rresp, resp;
  logic [DATA_W-1:0]   o_s_axi_rdata, rdat;
  logic [7:0]          i_buf_rd_addr;
  logic [15:0]         o_buf_rd_data;
  prog_cmd_type        o_prog_cmd, seen_cmd;
  logic                fail_next = 1'h0;
  logic [3:0]          delay = 4'h0;
  int                  n_fail = 0, total_checks = 0;
  logic [37:0]         rst_tab [9] = '{{OFF_FEATURE, 32'h0}, {OFF_LENGTH, 32'h1},
    {OFF_ADDR_LOW, 32'h1}, {OFF_ADDR_MID, 32'h0}, {OFF_ADDR_HIGH, 32'h0}, {OFF_UNIT, 32'hA0},
    {OFF_CMD_STAT, 32'h40}, {OFF_ERROR, 32'h0}, {OFF_BLOCK_CFG, 32'h0}};
  logic [7:0]          ops [5] = '{OP_WRITE_A, OP_WRITE_B, OP_WRITE_NOERASE, OP_WRITE_VERIFY,
    OP_BLOCK_NOERASE};
  ata_sector_write_commands ata_sector_write_commands_i (.*);
  flash_engine_model flash_engine_model_i (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_start(o_prog_start), .i_cmd(o_prog_cmd), .i_fail_next(fail_next), .i_delay(delay),
    .o_done(i_prog_done), .o_fail(i_prog_fail), .o_rd_addr(i_buf_rd_addr),
    .o_last_cmd(seen_cmd));
  always #5 i_clk_sys = ~i_clk_sys;
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'h1;
    i_s_axi_wvalid <= 1'h1;
    do begin
      @(posedge i_clk_sys);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
    end while (!o_s_axi_bvalid);
    i_s_axi_bready <= 1'h1;
    @(posedge i_clk_sys);
    resp = o_s_axi_bresp;
    i_s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [5:0] a);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'h1;
    do begin
      @(posedge i_clk_sys);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
    end while (!o_s_axi_rvalid);
    i_s_axi_rready <= 1'h1;
    @(posedge i_clk_sys);
    rdat = o_s_axi_rdata;
    resp = o_s_axi_rresp;
    i_s_axi_rready <= 1'h0;
  endtask
  task automatic chk_reg(input logic [5:0] a, input logic [31:0] e);
    rd(a);
    `CHK("register", e, rdat)
  endtask
  // bsy, drq, err; the status read also clears the interrupt
  task automatic chk_stat(input logic [2:0] e);
    rd(OFF_CMD_STAT);
    `CHK("status", e, {rdat[STAT_BSY_BIT], rdat[STAT_DRQ_BIT], rdat[STAT_ERR_BIT]})
    `CHK("irq clear", 1'h0, o_host_intrq)
  endtask
  task automatic wait_irq();
    int t;
    t = 0;
    while (o_host_intrq !== 1'h1 && t < 600) begin
      @(posedge i_clk_sys);
      t++;
    end
    `CHK("irq", 1'h1, o_host_intrq)
  endtask
  task automatic sector();
    for (int i = 0; i < SECTOR_WORDS; i++) wr(OFF_DATA, 32'hA500 + i);
    wait_irq();
  endtask
  task automatic run(input logic [7:0] op, input int k);
    logic [7:0] lo;
    lo = 8'h40 + 8'(k);
    delay <= 4'(k * 3);
    wr(OFF_UNIT, 32'hE0);
    wr(OFF_ADDR_MID, 32'h12);
    wr(OFF_ADDR_LOW, {24'h0, lo});
    wr(OFF_LENGTH, 32'h2);
    wr(OFF_CMD_STAT, {24'h0, op});
    repeat (4) @(posedge i_clk_sys);
    `CHK("first irq", 1'h0, o_host_intrq)
    chk_stat(3'h2);
    sector();
    `CHK("cmd", {12'h0, 8'h12, lo, 1'h1, op == 8'h38 || op == 8'hCD, op == 8'h3C}, seen_cmd)
    chk_stat(3'h2);
    `CHK("buffer", 16'hA500, o_buf_rd_data)
    chk_reg(OFF_ADDR_LOW, {24'h0, lo + 8'h1});
    chk_reg(OFF_LENGTH, 32'h1);
    wr(OFF_ADDR_MID, 32'h77);
    sector();
    `CHK("next addr", {12'h0, 8'h12, lo + 8'h1}, seen_cmd.addr)
    chk_stat(3'h0);
    chk_reg(OFF_LENGTH, 32'h0);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #300000;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_sys_rst <= 1'h0;
    @(posedge i_clk_sys);
    foreach (rst_tab[k]) chk_reg(rst_tab[k][37:32], rst_tab[k][31:0]);
    rd(6'h28);
    `CHK("bad read", RESP_SLVERR, resp)
    wr(6'h2C, 32'h0);
    `CHK("bad write", RESP_SLVERR, resp)
    wr(OFF_CMD_STAT, 32'hCD);
    wait_irq();
    chk_reg(OFF_ERROR, 32'h04);
    chk_stat(3'h1);
    wr(OFF_BLOCK_CFG, 32'h101);
    i_s_axi_wstrb <= 4'h0;
    wr(OFF_FEATURE, 32'h5A);
    i_s_axi_wstrb <= 4'hF;
    chk_reg(OFF_FEATURE, 32'h0);
    wr(OFF_FEATURE, 32'h5A);
    chk_reg(OFF_FEATURE, 32'h5A);
    foreach (ops[k]) run(ops[k], k);
    delay <= 4'h5;
    wr(OFF_UNIT, 32'hA0);
    wr(OFF_ADDR_MID, 32'h05);
    wr(OFF_ADDR_LOW, 32'h3F);
    wr(OFF_LENGTH, 32'h0);
    wr(OFF_CMD_STAT, 32'h31);
    chk_stat(3'h2);
    sector();
    `CHK("chs cmd", {12'h0, 8'h05, 8'h3F, 3'h0}, seen_cmd)
    chk_reg(OFF_ADDR_LOW, 32'h01);
    chk_reg(OFF_UNIT, 32'hA1);
    chk_reg(OFF_LENGTH, 32'hFF);
    chk_stat(3'h2);
    fail_next <= 1'h1;
    sector();
    chk_reg(OFF_ERROR, 32'h40);
    chk_stat(3'h1);
    chk_reg(OFF_ADDR_LOW, 32'h01);
    chk_reg(OFF_UNIT, 32'hA1);
    chk_reg(OFF_LENGTH, 32'hFF);
    complete_run();
  end
endmodule // test_ata_sector_write_commands
`default_nettype wire
